// >>> src/sdc_map.vh
// register map, field positions and reset values of the synthesizer divider core
`ifndef SDC_MAP_VH
`define SDC_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SDC_CTRL_OFS 12'h000
`define SDC_DIV_OFS 12'h004
`define SDC_MAIN_OFS 12'h008
`define SDC_STAT_OFS 12'h00c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SDC_CTRL_MAIN_EN 0
`define SDC_CTRL_AUX_EN 1
`define SDC_CTRL_AUX_BYP 2
`define SDC_CTRL_FRAC_MODULUS_SELECT 3
`define SDC_CTRL_MSEL_LO 4
`define SDC_CTRL_ASEL_LO 6
`define SDC_CTRL_NF_LO 8
`define SDC_CTRL_RST 32'h0000_0000

// ----------------------------------------------------------------
// divider ratio register fields
// ----------------------------------------------------------------
`define SDC_DIV_REF_LO 0
`define SDC_DIV_AUX_LO 16
`define SDC_DIV_RST 32'h0004_0004

// ----------------------------------------------------------------
// main divider register fields
// ----------------------------------------------------------------
`define SDC_MAIN_NM1_LO 0
`define SDC_MAIN_NM2_LO 12
`define SDC_MAIN_NM3_LO 20
`define SDC_MAIN_NM4_LO 24
`define SDC_MAIN_PR_LO 28
`define SDC_MAIN_RST 32'h3000_0004

// ----------------------------------------------------------------
// prescaler types and fractional moduli
// ----------------------------------------------------------------
`define SDC_PR_MOD4_NO3 2'h0
`define SDC_PR_MOD2 2'h1
`define SDC_PR_MOD3 2'h2
`define SDC_PR_MOD4 2'h3
`define SDC_FRAC_Q8 4'h8
`define SDC_FRAC_Q5 4'h5

`endif

// >>> src/sdc_core.v
// divider, fractional accumulator and phase detector core of a dual synthesizer
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.vh"

module sdc_core #(
  parameter AUX_W = 9,
  parameter REF_W = 9
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // divider inputs, sampled on pclk
  input wire aux_divider_in,
  input wire ref_divider_in,
  input wire main_in_pos,
  input wire main_in_neg,
  // prescaler modulus control
  output wire modulus_ctl_a,
  output wire modulus_ctl_b,
  // charge pump requests
  output reg prop_pump_up,
  output reg prop_pump_dn,
  output reg aux_pump_up,
  output reg aux_pump_dn,
  // fractional compensation value
  output reg [2:0] frac_accum_value
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg [31:0] ctrl;
  reg [31:0] div_cfg;
  reg [31:0] main_pend;
  reg load_pending;
  wire wr_en;
  wire main_load;

  wire main_path_enable = ctrl[`SDC_CTRL_MAIN_EN];
  wire aux_path_enable = ctrl[`SDC_CTRL_AUX_EN];
  wire aux_prescale_bypass = ctrl[`SDC_CTRL_AUX_BYP];
  wire frac_modulus_select = ctrl[`SDC_CTRL_FRAC_MODULUS_SELECT];
  wire [1:0] main_ref_pulse_select = ctrl[`SDC_CTRL_MSEL_LO +: 2];
  wire [1:0] aux_ref_pulse_select = ctrl[`SDC_CTRL_ASEL_LO +: 2];
  wire [2:0] frac_increment = ctrl[`SDC_CTRL_NF_LO +: 3];
  wire [REF_W-1:0] ref_divide_ratio = div_cfg[`SDC_DIV_REF_LO +: REF_W];
  wire [AUX_W-1:0] aux_divide_ratio = div_cfg[`SDC_DIV_AUX_LO +: AUX_W];

  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1; // every access completes in its first access cycle
  assign pslverr = psel & penable & (paddr[11:2] > `SDC_STAT_OFS >> 2 || paddr[1:0] != 2'h0);

  // register writes; main settings only stage here and wait for the counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SDC_CTRL_RST;
      div_cfg <= `SDC_DIV_RST;
      main_pend <= `SDC_MAIN_RST;
      load_pending <= 1'b0;
    end else begin
      if (wr_en && paddr == `SDC_CTRL_OFS) begin
        ctrl <= {21'h0, pwdata[10:0]};
      end
      if (wr_en && paddr == `SDC_DIV_OFS) begin
        div_cfg <= {7'h0, pwdata[24:16], 7'h0, pwdata[8:0]};
      end
      if (wr_en && paddr == `SDC_MAIN_OFS) begin
        main_pend <= {2'h0, pwdata[29:0]};
        load_pending <= 1'b1;
      end else if (main_load) begin
        load_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // input edge detection
  // ----------------------------------------------------------------
  reg aux_in_q;
  reg ref_in_q;
  reg main_in_q;
  wire ref_enable = aux_path_enable | main_path_enable;
  wire aux_tick = aux_path_enable & aux_divider_in & ~aux_in_q;
  wire ref_tick = ref_enable & ref_divider_in & ~ref_in_q;
  // the comparator counts a cycle on a rising positive leg with the negative leg low
  wire main_tick = main_path_enable & main_in_pos & ~main_in_neg & ~main_in_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_in_q <= 1'b0;
      ref_in_q <= 1'b0;
      main_in_q <= 1'b0;
    end else begin
      aux_in_q <= aux_divider_in;
      ref_in_q <= ref_divider_in;
      main_in_q <= main_in_pos & ~main_in_neg;
    end
  end

  // ----------------------------------------------------------------
  // auxiliary divider
  // ----------------------------------------------------------------
  reg [1:0] aux_pre;
  reg [AUX_W-1:0] aux_cnt;
  reg aux_out_fall;
  wire aux_stage_tick = aux_tick & (aux_prescale_bypass | aux_pre == 2'h3);

  // counter holds while disabled so re-enable resumes cleanly
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_pre <= 2'h0;
      aux_cnt <= {AUX_W{1'b0}};
      aux_out_fall <= 1'b0;
    end else begin
      aux_out_fall <= 1'b0;
      if (aux_tick && !aux_prescale_bypass) begin
        aux_pre <= aux_pre + 2'h1;
      end
      if (aux_stage_tick) begin
        if (aux_cnt + 1'b1 >= aux_divide_ratio) begin
          aux_cnt <= {AUX_W{1'b0}};
          aux_out_fall <= 1'b1;
        end else begin
          aux_cnt <= aux_cnt + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reference divider and pulse positions
  // ----------------------------------------------------------------
  reg [REF_W-1:0] ref_cnt;
  reg ref_div_out;
  reg [2:0] ref_phase;
  reg [3:0] ref_pulse;
  // high half is the longer one on odd ratios
  wire [REF_W-1:0] ref_high_len = ref_divide_ratio - (ref_divide_ratio >> 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= {REF_W{1'b0}};
      ref_div_out <= 1'b1;
      ref_phase <= 3'h0;
      ref_pulse <= 4'h0;
    end else begin
      ref_pulse <= 4'h0;
      if (ref_tick) begin
        if (ref_cnt + 1'b1 >= ref_divide_ratio) begin
          ref_cnt <= {REF_W{1'b0}};
          ref_div_out <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + 1'b1;
          if (ref_cnt + 1'b1 == ref_high_len) begin
            ref_div_out <= 1'b0;
            ref_phase <= ref_phase + 3'h1;
          end
        end
      end
      if (ref_tick && ref_cnt + 1'b1 == ref_high_len && ref_cnt + 1'b1 < ref_divide_ratio) begin
        ref_pulse[ref_phase[2:1] + 2'h1] <= ~ref_phase[0]; // four positions, one each 8 periods
      end
    end
  end

  wire main_ref_fall = ref_pulse[main_ref_pulse_select] & main_path_enable;
  wire aux_ref_fall = ref_pulse[aux_ref_pulse_select] & aux_path_enable;

  // ----------------------------------------------------------------
  // main divider
  // ----------------------------------------------------------------
  localparam PH_R1 = 2'h0;
  localparam PH_R2 = 2'h1;
  localparam PH_R3 = 2'h2;
  localparam PH_R4 = 2'h3;

  reg [1:0] phase;
  reg [12:0] main_cnt;
  reg [31:0] main_work;
  reg ovf_pend;
  reg [3:0] frac_acc;
  reg main_out_fall;
  reg [1:0] next_phase;
  reg [12:0] next_cnt;
  reg cycle_end;

  wire [11:0] nm1 = main_work[`SDC_MAIN_NM1_LO +: 12];
  wire [1:0] prescaler_type = main_work[`SDC_MAIN_PR_LO +: 2];
  // upper nibble of the R2 count only exists for modulus 2
  wire [7:0] nm2 = (prescaler_type == `SDC_PR_MOD2) ? main_work[`SDC_MAIN_NM2_LO +: 8] :
    {4'h0, main_work[`SDC_MAIN_NM2_LO +: 4]};
  wire [3:0] nm3 = main_work[`SDC_MAIN_NM3_LO +: 4];
  wire [3:0] nm4 = main_work[`SDC_MAIN_NM4_LO +: 4];
  wire [12:0] r1_start = 13'h0 - {1'b0, nm1} - 13'h1;
  wire r3_used = prescaler_type[1];
  wire r4_used = prescaler_type == `SDC_PR_MOD4 || prescaler_type == `SDC_PR_MOD4_NO3;
  wire [3:0] frac_q = frac_modulus_select ? `SDC_FRAC_Q8 : `SDC_FRAC_Q5;
  wire [3:0] frac_sum = frac_acc + {1'b0, frac_increment};
  wire [7:0] r2_end = nm2;
  assign main_load = cycle_end & main_tick;

  // phase sequencing on each counted main input cycle
  always @* begin
    next_phase = phase;
    next_cnt = main_cnt + 13'h1;
    cycle_end = 1'b0;
    case (phase)
      PH_R1: begin
        // overflow ends R1 one count early at minus one
        if (main_cnt == (ovf_pend ? 13'h1fff : 13'h0)) begin
          next_phase = PH_R2;
          next_cnt = ovf_pend ? 13'h0 : 13'h1;
          if (!ovf_pend && r2_end == 8'h0) begin
            next_phase = r3_used ? PH_R3 : (r4_used ? PH_R4 : PH_R1);
            next_cnt = 13'h0;
            cycle_end = !r3_used && !r4_used;
          end
        end
      end
      PH_R2: begin
        if (main_cnt == {5'h0, r2_end}) begin
          next_phase = r3_used ? PH_R3 : (r4_used ? PH_R4 : PH_R1);
          next_cnt = 13'h0;
          cycle_end = !r3_used && !r4_used;
        end
      end
      PH_R3: begin
        if (main_cnt == {9'h0, nm3}) begin
          next_phase = r4_used ? PH_R4 : PH_R1;
          next_cnt = 13'h0;
          cycle_end = !r4_used;
        end
      end
      PH_R4: begin
        if (main_cnt == {9'h0, nm4}) begin
          next_phase = PH_R1;
          cycle_end = 1'b1;
        end
      end
      default: begin
        next_phase = PH_R1;
        cycle_end = 1'b1;
      end
    endcase
  end

  // counter, working copy of settings and fractional accumulator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_R1;
      main_cnt <= 13'h0;
      main_work <= `SDC_MAIN_RST;
      ovf_pend <= 1'b0;
      frac_acc <= 4'h0;
      main_out_fall <= 1'b0;
      frac_accum_value <= 3'h0;
    end else begin
      main_out_fall <= 1'b0;
      frac_accum_value <= frac_acc[2:0];
      if (main_tick) begin
        phase <= next_phase;
        main_cnt <= next_cnt;
        if (phase == PH_R1 && main_cnt == (ovf_pend ? 13'h1fff : 13'h0)) begin
          ovf_pend <= 1'b0; // overflow consumed by this cycle
        end
        if (cycle_end) begin
          main_out_fall <= 1'b1;
          // settings swap only here, so a ratio never changes mid cycle
          if (load_pending) begin
            main_work <= main_pend;
          end
          main_cnt <= 13'h0 - {1'b0, load_pending ? main_pend[11:0] : nm1} - 13'h1;
          if (frac_sum >= frac_q) begin
            frac_acc <= frac_sum - frac_q;
            ovf_pend <= 1'b1;
          end else begin
            frac_acc <= frac_sum;
          end
        end
      end
      if (!main_path_enable && r1_start == 13'h0) begin
        main_cnt <= 13'h0;
      end
    end
  end

  // modulus outputs decode straight from the phase register
  assign modulus_ctl_a = phase == PH_R1 || phase == PH_R4;
  assign modulus_ctl_b = phase == PH_R3 || phase == PH_R4;

  // ----------------------------------------------------------------
  // phase frequency detectors
  // ----------------------------------------------------------------
  // clear enable is low for one pclk cycle on each reference input rising edge while either path is enabled, giving the reset delay
  wire pfd_clear_en_n = ~ref_tick;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prop_pump_up <= 1'b0;
      prop_pump_dn <= 1'b0;
      aux_pump_up <= 1'b0;
      aux_pump_dn <= 1'b0;
    end else begin
      if (prop_pump_up && prop_pump_dn && !pfd_clear_en_n) begin
        prop_pump_up <= 1'b0;
        prop_pump_dn <= 1'b0;
      end else begin
        // reference ahead of divider means the oscillator is slow
        if (main_ref_fall) prop_pump_up <= 1'b1;
        if (main_out_fall) prop_pump_dn <= 1'b1;
      end
      if (aux_pump_up && aux_pump_dn && !pfd_clear_en_n) begin
        aux_pump_up <= 1'b0;
        aux_pump_dn <= 1'b0;
      end else begin
        if (aux_ref_fall) aux_pump_up <= 1'b1;
        if (aux_out_fall) aux_pump_dn <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read-back
  // ----------------------------------------------------------------
  always @* begin
    prdata = 32'h0;
    if (psel && !pwrite) begin
      case (paddr)
        `SDC_CTRL_OFS: prdata = ctrl;
        `SDC_DIV_OFS: prdata = div_cfg;
        `SDC_MAIN_OFS: prdata = main_pend;
        `SDC_STAT_OFS: prdata = {20'h0, modulus_ctl_b, modulus_ctl_a, phase, aux_pump_dn, aux_pump_up,
          prop_pump_dn, prop_pump_up, load_pending, frac_acc[2:0]};
        default: prdata = 32'h0;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> verif/sdc_core_asserts.sv
// port-level assertions for the synthesizer divider core
`timescale 1ns/10ps
`default_nettype none
module sdc_core_asserts (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // core outputs
  input wire logic modulus_ctl_a,
  input wire logic modulus_ctl_b,
  input wire logic prop_pump_up,
  input wire logic prop_pump_dn,
  input wire logic aux_pump_up,
  input wire logic aux_pump_dn,
  input wire logic [2:0] frac_accum_value
);
  logic [10:0] ctl;
  logic [3:0] mh;
  logic [3:0] ah;
  logic q8;
  wire wr_ctl = psel && penable && pwrite && paddr == 12'h000;
  // control shadow; enable history spans the input sampling pipeline
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 11'h000;
      mh <= 4'h0;
      ah <= 4'h0;
      q8 <= 1'b0;
    end else begin
      if (wr_ctl)
        ctl <= pwdata[10:0];
      mh <= {mh[2:0], ctl[0]};
      ah <= {ah[2:0], ctl[1]};
      q8 <= q8 | (wr_ctl & pwdata[3]);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_main_idle;
    !ctl[0] && mh == 4'h0 |=> $stable(frac_accum_value) && $stable({modulus_ctl_a, modulus_ctl_b})
      && !$rose(prop_pump_dn);
  endproperty
  a_main_idle: assert property (p_main_idle) else $error("main path moved while off");
  property p_aux_idle;
    !ctl[1] && ah == 4'h0 |=> !$rose(aux_pump_dn);
  endproperty
  a_aux_idle: assert property (p_aux_idle) else $error("aux path moved while off");
  property p_ref_idle;
    ctl[1:0] == 2'h0 && mh == 4'h0 && ah == 4'h0 |=> !$rose(prop_pump_up) && !$rose(aux_pump_up);
  endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("reference moved while off");
  property p_pair_main;
    $fell(prop_pump_up) || $fell(prop_pump_dn) |-> $past(prop_pump_up) && $past(prop_pump_dn);
  endproperty
  a_pair_main: assert property (p_pair_main) else $error("main detector cleared early");
  property p_pair_aux;
    $fell(aux_pump_up) || $fell(aux_pump_dn) |-> $past(aux_pump_up) && $past(aux_pump_dn);
  endproperty
  a_pair_aux: assert property (p_pair_aux) else $error("aux detector cleared early");
  property p_q5;
    !q8 |-> frac_accum_value < 3'h5;
  endproperty
  a_q5: assert property (p_q5) else $error("accumulator beyond modulus five");
  property p_order;
    $past(modulus_ctl_b) && $changed({modulus_ctl_a, modulus_ctl_b}) |-> modulus_ctl_a;
  endproperty
  a_order: assert property (p_order) else $error("modulus phase order broken");
  property p_apb_resp;
    psel && penable |-> pready && pslverr == (paddr > 12'h00c || paddr[1:0] != 2'h0);
  endproperty
  a_apb_resp: assert property (p_apb_resp) else $error("bad apb response");
endmodule
bind sdc_core sdc_core_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .modulus_ctl_a(modulus_ctl_a),
  .modulus_ctl_b(modulus_ctl_b), .prop_pump_up(prop_pump_up), .prop_pump_dn(prop_pump_dn),
  .aux_pump_up(aux_pump_up), .aux_pump_dn(aux_pump_dn), .frac_accum_value(frac_accum_value)
);
`default_nettype wire

// >>> verif/sdc_prescaler_model.sv
// behavioural four-modulus prescaler whose period follows the modulus request
`timescale 1ns/10ps
`default_nettype none
module sdc_prescaler_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stretch each output cycle
  input wire logic slow,
  // modulus request from the core
  input wire logic modulus_ctl_a,
  input wire logic modulus_ctl_b,
  // balanced output pair
  output var logic main_in_pos,
  output wire logic main_in_neg
);
  logic [3:0] cnt;
  logic [3:0] half;
  // larger ratio keeps each half longer, as a real prescaler would
  assign half = {2'h0, modulus_ctl_a, modulus_ctl_b} + (slow ? 4'h6 : 4'h2);
  assign main_in_neg = ~main_in_pos;
  // the oscillator never stops, so the pair toggles whenever out of reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      main_in_pos <= 1'b0;
    end else if (cnt >= half) begin
      cnt <= 4'h0;
      main_in_pos <= ~main_in_pos;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_synth_divider_core.sv
// self-checking bench for the synthesizer divider core
`timescale 1ns/10ps
`default_nettype none
module tb_synth_divider_core;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, slow, aux_in, ref_in;
  logic mca, mcb, mpos, mneg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] t, tick;
  logic [2:0] frac;
  int miscompares, check_count, i, n, ov, cnt[4], a0, fa;
  // type, modulus select, increment, cycles measured, overflows expected
  int rows [6][5] = '{'{1, 0, 0, 4, 0}, '{2, 0, 0, 4, 0}, '{3, 0, 0, 4, 0}, '{0, 0, 0, 4, 0},
    '{1, 1, 4, 4, 2}, '{1, 0, 2, 5, 2}};
  sdc_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .aux_divider_in(aux_in),
    .ref_divider_in(ref_in), .main_in_pos(mpos), .main_in_neg(mneg), .modulus_ctl_a(mca),
    .modulus_ctl_b(mcb), .prop_pump_up(), .prop_pump_dn(), .aux_pump_up(), .aux_pump_dn(),
    .frac_accum_value(frac)
  );
  sdc_prescaler_model u_pre (
    .clk(pclk), .rst_n(presetn), .slow(slow), .modulus_ctl_a(mca), .modulus_ctl_b(mcb),
    .main_in_pos(mpos), .main_in_neg(mneg)
  );
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // crystal and aux oscillator stand-ins, both free running
  always @(posedge pclk) begin
    ref_in <= ~ref_in;
    tick <= tick + 2'h1;
    if (tick == 2'h3)
      aux_in <= ~aux_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the idle edge after it keeps drives one per time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, d);
    chk({31'h0, er}, {31'h0, e});
  endtask
  // tally main input cycles by the modulus in force, over n whole divider cycles
  task automatic measure(input int n);
    int k;
    logic p, r;
    k = -2;
    p = 1'b1;
    r = 1'b1;
    cnt = '{0, 0, 0, 0};
    while (k < n) begin
      @(posedge pclk);
      // accumulator copy lags by one cycle end at each start marker, so n markers span n additions
      if (mca && !mcb && !r) begin
        k++;
        if (k == 0)
          a0 = frac;
        if (k == n)
          fa = frac;
      end
      if (k >= 0 && k < n && mpos && !p)
        cnt[{mcb, mca}]++;
      p = mpos;
      r = mca && !mcb;
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, aux_in, ref_in, slow} = 7'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tick = 2'h0;
    miscompares = 0;
    check_count = 0;
    do_reset();
    // one row per prescaler type and fraction setting
    for (i = 0; i < 6; i++) begin
      t = rows[i][0][1:0];
      n = rows[i][3];
      ov = rows[i][4];
      slow <= i[0];
      apb(1'b1, 12'h008, {2'h0, t, 16'h2102, 12'h003});
      apb(1'b1, 12'h000, {21'h0, rows[i][2][2:0], 4'h8, rows[i][1][0], 3'h3});
      measure(n);
      chk(cnt[1], n * 5 - ov);
      chk(cnt[0], n * 2 + ov);
      chk(cnt[2], t[1] ? n * 2 : 0);
      chk(cnt[3], (t == 2'h3 || t == 2'h0) ? n * 3 : 0);
      chk(fa, (a0 + n * rows[i][2]) % (rows[i][1] ? 8 : 5));
      chk({31'h0, a0 >= (rows[i][1] ? 8 : 5)}, 32'h0);
    end
    // second reset mid-run, then register image and refusals
    do_reset();
    rd_chk(12'h000, 32'h0000_0000, 1'b0);
    rd_chk(12'h004, 32'h0004_0004, 1'b0);
    rd_chk(12'h008, 32'h3000_0004, 1'b0);
    rd_chk(12'h00c, 32'h0000_0400, 1'b0);
    rd_chk(12'h010, 32'h0000_0000, 1'b1);
    rd_chk(12'h006, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h004, 32'h01ff_01ff);
    rd_chk(12'h004, 32'h01ff_01ff, 1'b0);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    rd_chk(12'h00c, 32'h0000_0400, 1'b0);
    // new main settings wait for an enabled cycle end
    apb(1'b1, 12'h008, 32'h1000_2003);
    repeat (200) @(posedge pclk);
    rd_chk(12'h00c, 32'h0000_0408, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0001);
    measure(1);
    chk(cnt[1], 5);
    chk(cnt[3], 0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, rd[3]}, 32'h0);
    give_verdict();
  end
  // cut a hang short; the full run needs less than a tenth of this
  initial begin
    #2400000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
